// >>> lrc_top.sv
// Receive path control bank for three line channels
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module lrc_top #(
  parameter int NUM_CH = lrc_pkg::NUM_CH
) (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic [lrc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [lrc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                      wr_en_i,
  input  wire logic                      rd_en_i,
  output logic      [lrc_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic [NUM_CH-1:0]         e3_mode_i,
  input  wire logic [NUM_CH-1:0]         digital_signal_loss_detector_i,
  input  wire logic [NUM_CH-1:0]         analog_signal_loss_detector_i,
  output logic      [NUM_CH-1:0]         digital_detector_enable_o,
  output logic      [NUM_CH-1:0]         analog_detector_enable_o,
  output logic      [NUM_CH-1:0]         monitor_mode_o,
  output logic      [NUM_CH-1:0]         equalizer_enable_o,
  output logic      [NUM_CH-1:0]         signal_loss_o,
  input  wire logic [NUM_CH-1:0]         recovered_clock_i,
  input  wire logic [NUM_CH-1:0]         rx_pos_i,
  input  wire logic [NUM_CH-1:0]         rx_neg_i,
  output logic      [NUM_CH-1:0]         recovered_clock_o,
  output logic      [NUM_CH-1:0]         recovered_positive_rail_o,
  output logic      [NUM_CH-1:0]         recovered_negative_rail_o
);

  localparam int CW = lrc_pkg::CTRL_W;

  logic [CW-1:0]     ctrl [NUM_CH];
  logic [NUM_CH-1:0] dig_loss_s;
  logic [NUM_CH-1:0] ana_loss_s;
  logic [NUM_CH-1:0] dig_en;
  logic [NUM_CH-1:0] ana_en;
  logic [NUM_CH-1:0] mute_req;
  logic [NUM_CH-1:0] edge_sel;

  // Channel index of a control register offset, or NUM_CH if none
  function automatic logic [1:0] ctrl_chan(
    input logic [lrc_pkg::ADDR_W-1:0] a
  );
    case (a)
      lrc_pkg::RX_CTRL_CH0_OFS: ctrl_chan = 2'h0;
      lrc_pkg::RX_CTRL_CH1_OFS: ctrl_chan = 2'h1;
      lrc_pkg::RX_CTRL_CH2_OFS: ctrl_chan = 2'h2;
      default:                  ctrl_chan = 2'h3;
    endcase
  endfunction

  // Detector flags arrive from the analog front end, outside this clock
  lrc_sync #(.WIDTH(2*NUM_CH)) u_loss_sync (
    .clk_i (mclk_i),
    .d_i   ({digital_signal_loss_detector_i,
             analog_signal_loss_detector_i}),
    .q_o   ({dig_loss_s, ana_loss_s})
  );

  // Control registers; the equalizer bit is left for software to set
  always_ff @(posedge mclk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!resetn_i) begin
        ctrl[c] <= lrc_pkg::CTRL_RESET;
      end else if (wr_en_i && ctrl_chan(addr_i) == 2'(c)) begin
        ctrl[c] <= wr_data_i[CW-1:0];
      end
    end
  end

  // Readback: unused bits and unmapped offsets read zero
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= '0;
      if (ctrl_chan(addr_i) != 2'h3) begin
        rd_data_o[CW-1:0] <= ctrl[ctrl_chan(addr_i)];
      end else if (addr_i == lrc_pkg::RX_STATUS_OFS) begin
        rd_data_o[lrc_pkg::STAT_LOS_LSB +: NUM_CH] <= signal_loss_o;
        rd_data_o[lrc_pkg::STAT_E3_LSB +: NUM_CH]  <= e3_mode_i;
      end
    end
  end

  // E3 keeps both detectors running whatever the disable bits say
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      dig_en[c] = e3_mode_i[c] | ~ctrl[c][lrc_pkg::DIGITAL_SIGNAL_LOSS_DETECTOR_DIS_BIT];
      ana_en[c] = e3_mode_i[c] | ~ctrl[c][lrc_pkg::ANALOG_SIGNAL_LOSS_DETECTOR_DIS_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      digital_detector_enable_o <= '1;
      analog_detector_enable_o  <= '1;
      monitor_mode_o            <= '0;
      equalizer_enable_o        <= '0;
    end else begin
      digital_detector_enable_o <= dig_en;
      analog_detector_enable_o  <= ana_en;
      for (int c = 0; c < NUM_CH; c++) begin
        monitor_mode_o[c]     <= ctrl[c][lrc_pkg::MON_MODE_BIT];
        equalizer_enable_o[c] <= ctrl[c][lrc_pkg::EQ_EN_BIT];
      end
    end
  end

  // A disabled detector is masked here so a stale flag cannot mute data
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      signal_loss_o <= '0;
      mute_req      <= '0;
      edge_sel      <= '0;
    end else begin
      signal_loss_o <= (dig_loss_s & dig_en) | (ana_loss_s & ana_en);
      for (int c = 0; c < NUM_CH; c++) begin
        mute_req[c] <= ctrl[c][lrc_pkg::MUTE_EN_BIT] &
                       ((dig_loss_s[c] & dig_en[c]) |
                        (ana_loss_s[c] & ana_en[c]));
        edge_sel[c] <= ctrl[c][lrc_pkg::EDGE_SEL_BIT];
      end
    end
  end

  assign recovered_clock_o = recovered_clock_i;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_lane
    lrc_rx_lane u_lane (
      .rclk_i                    (recovered_clock_i[g]),
      .resetn_i                  (resetn_i),
      .mute_i                    (mute_req[g]),
      .edge_sel_i                (edge_sel[g]),
      .rx_pos_i                  (rx_pos_i[g]),
      .rx_neg_i                  (rx_neg_i[g]),
      .recovered_positive_rail_o (recovered_positive_rail_o[g]),
      .recovered_negative_rail_o (recovered_negative_rail_o[g])
    );
  end

endmodule

// >>> lrc_pkg.sv
// Shared constants for the per-channel receive path control bank
package lrc_pkg;

  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Receive control register of each channel
  localparam logic [7:0] RX_CTRL_CH0_OFS = 8'h05;
  localparam logic [7:0] RX_CTRL_CH1_OFS = 8'h0d;
  localparam logic [7:0] RX_CTRL_CH2_OFS = 8'h15;
  // Status register: per-channel signal loss declaration and rate mode
  localparam logic [7:0] RX_STATUS_OFS   = 8'h18;

  // Field positions of receive_path_control
  localparam int DIGITAL_SIGNAL_LOSS_DETECTOR_DIS_BIT = 5;
  localparam int ANALOG_SIGNAL_LOSS_DETECTOR_DIS_BIT = 4;
  localparam int EDGE_SEL_BIT = 3;
  localparam int MUTE_EN_BIT  = 2;
  localparam int MON_MODE_BIT = 1;
  localparam int EQ_EN_BIT    = 0;

  // Bits 7..6 are read-only zero; only 5..0 are stored
  localparam int         CTRL_W     = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Status register field positions
  localparam int STAT_LOS_LSB = 0;
  localparam int STAT_E3_LSB  = 4;

  // Depth of every synchroniser
  localparam int SYNC_STAGES = 2;

endpackage

// >>> lrc_sync.sv
// Two flip-flop level synchroniser into the destination clock
`timescale 1ns/100ps
module lrc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end

endmodule

// >>> lrc_rx_lane.sv
// Recovered-clock side of one channel: muting and output edge selection
`timescale 1ns/100ps
module lrc_rx_lane (
  input  wire logic rclk_i,
  input  wire logic resetn_i,
  input  wire logic mute_i,
  input  wire logic edge_sel_i,
  input  wire logic rx_pos_i,
  input  wire logic rx_neg_i,
  output logic      recovered_positive_rail_o,
  output logic      recovered_negative_rail_o
);

  logic       link_resetn;
  logic [1:0] ctrl_sync;
  logic       mute_s;
  logic       edge_s;
  logic       rise_pos;
  logic       rise_neg;
  logic       fall_pos;
  logic       fall_neg;

  lrc_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i (rclk_i),
    .d_i   (resetn_i),
    .q_o   (link_resetn)
  );

  lrc_sync #(.WIDTH(2)) u_ctrl_sync (
    .clk_i (rclk_i),
    .d_i   ({mute_i, edge_sel_i}),
    .q_o   (ctrl_sync)
  );

  assign mute_s = ctrl_sync[1];
  assign edge_s = ctrl_sync[0];

  // Muted data is forced low at the launch flop, so both edges see it
  always_ff @(posedge rclk_i) begin
    if (!link_resetn) begin
      rise_pos <= 1'b0;
      rise_neg <= 1'b0;
    end else begin
      rise_pos <= mute_s ? 1'b0 : rx_pos_i;
      rise_neg <= mute_s ? 1'b0 : rx_neg_i;
    end
  end

  // Half-cycle retimed copy, launched on the falling edge
  always_ff @(negedge rclk_i) begin
    if (!link_resetn) begin
      fall_pos <= 1'b0;
      fall_neg <= 1'b0;
    end else begin
      fall_pos <= rise_pos;
      fall_neg <= rise_neg;
    end
  end

  assign recovered_positive_rail_o = edge_s ? fall_pos : rise_pos;
  assign recovered_negative_rail_o = edge_s ? fall_neg : rise_neg;

endmodule

// >>> lrc_framer.sv
// Framer-side model watching the channel 0 recovered rails
`timescale 1ns/100ps
module lrc_framer (
  input  wire logic clk_i,
  input  wire logic pos_i,
  input  wire logic neg_i,
  input  wire logic clr_i,
  output logic      edge_o,
  output logic      ones_o
);
  // Clock level at a rail change shows which edge launched it
  always @(pos_i) edge_o = clk_i;
  always @(posedge clk_i or posedge clr_i) begin
    if (clr_i) ones_o <= 1'b0;
    else if (pos_i || neg_i) ones_o <= 1'b1;
  end
endmodule

// >>> lrc_top_chk.sv
// Port assertions for the receive path control bank
`timescale 1ns/100ps
module lrc_top_chk #(
  parameter int NUM_CH = 3
) (
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  input wire logic [7:0]        addr_i,
  input wire logic [7:0]        wr_data_i,
  input wire logic              wr_en_i,
  input wire logic              rd_en_i,
  input wire logic [7:0]        rd_data_o,
  input wire logic [NUM_CH-1:0] e3_mode_i,
  input wire logic [NUM_CH-1:0] digital_signal_loss_detector_i,
  input wire logic [NUM_CH-1:0] analog_signal_loss_detector_i,
  input wire logic [NUM_CH-1:0] digital_detector_enable_o,
  input wire logic [NUM_CH-1:0] analog_detector_enable_o,
  input wire logic [NUM_CH-1:0] monitor_mode_o,
  input wire logic [NUM_CH-1:0] equalizer_enable_o,
  input wire logic [NUM_CH-1:0] signal_loss_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_dig_disable: assert property (
    wr_en_i && addr_i == 8'h05 && wr_data_i[5] && !e3_mode_i[0]
    ##1 (!wr_en_i && !e3_mode_i[0])[*2] |-> !digital_detector_enable_o[0])
    else $error("digital detector still on");
  a_ana_disable: assert property (
    wr_en_i && addr_i == 8'h0d && wr_data_i[4] && !e3_mode_i[1]
    ##1 (!wr_en_i && !e3_mode_i[1])[*2] |-> !analog_detector_enable_o[1])
    else $error("analog detector still on");
  a_e3_forces_on: assert property (e3_mode_i[0][*3] |->
    digital_detector_enable_o[0] && analog_detector_enable_o[0])
    else $error("detector off in e3 mode");
  a_monitor_mode: assert property (wr_en_i && addr_i == 8'h05
    ##1 (!wr_en_i)[*2] |-> monitor_mode_o[0] == $past(wr_data_i[1], 2))
    else $error("monitor mode wrong");
  a_equalizer_bit: assert property (wr_en_i && addr_i == 8'h15
    ##1 (!wr_en_i)[*2] |-> equalizer_enable_o[2] == $past(wr_data_i[0], 2))
    else $error("equalizer enable wrong");
  a_ctrl_readback: assert property (wr_en_i && addr_i == 8'h15
    ##1 !wr_en_i ##1 rd_en_i && addr_i == 8'h15
    |=> rd_data_o == {2'h0, $past(wr_data_i[5:0], 3)})
    else $error("control readback wrong");
  a_off_no_loss: assert property (
    (!digital_detector_enable_o[0] && !analog_detector_enable_o[0])[*2]
    |-> !signal_loss_o[0]) else $error("loss from disabled detectors");
  a_loss_raised: assert property (
    (digital_signal_loss_detector_i[0] && digital_detector_enable_o[0])[*5]
    |-> signal_loss_o[0]) else $error("loss not declared");
  a_loss_cleared: assert property ((!digital_signal_loss_detector_i[0]
    && !analog_signal_loss_detector_i[0])[*5] |-> !signal_loss_o[0])
    else $error("loss without cause");
endmodule
bind lrc_top lrc_top_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// >>> lrc_top_tb_top.sv
// Self-checking bench for the receive path control bank
`timescale 1ns/100ps
module lrc_top_tb_top;
  logic       mclk_i = 1'b0, resetn_i = 1'b0, rc = 1'b0, clr = 1'b0;
  logic       wr_en_i = 1'b0, rd_en_i = 1'b0, lvl, ones;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
  logic [2:0] e3_mode_i = 3'h0, rx_pos_i = 3'h0, rx_neg_i = 3'h0;
  logic [2:0] digital_signal_loss_detector_i = 3'h0;
  logic [2:0] analog_signal_loss_detector_i = 3'h0;
  logic [2:0] digital_detector_enable_o, analog_detector_enable_o;
  logic [2:0] monitor_mode_o, equalizer_enable_o, signal_loss_o;
  logic [2:0] recovered_clock_o, recovered_positive_rail_o;
  logic [2:0] recovered_negative_rail_o;
  wire  [2:0] recovered_clock_i = {3{rc}};
  int         n_errors = 0, checks = 0;
  // Address, write data, expected read back
  logic [7:0] rows [4][3] = '{'{8'h05, 8'hff, 8'h3f},
    '{8'h0d, 8'h3a, 8'h3a}, '{8'h15, 8'h15, 8'h15}, '{8'h07, 8'hff, 8'h00}};
  lrc_top dut (.*);
  lrc_framer u_frm (.clk_i(recovered_clock_o[0]), .clr_i(clr),
    .pos_i(recovered_positive_rail_o[0]), .edge_o(lvl), .ones_o(ones),
    .neg_i(recovered_negative_rail_o[0]));
  initial forever #12.5 mclk_i = ~mclk_i;
  // Odd start offset keeps the link clock out of phase with mclk
  initial begin
    #7;
    forever #32 rc = ~rc;
  end
  always @(negedge rc) begin
    rx_pos_i <= ~rx_pos_i;
    rx_neg_i <= rx_pos_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    @(negedge mclk_i);
    d = rd_data_o;
  endtask
  // Mute and edge changes cross domains, so settle before watching
  task automatic obs(input logic e);
    cyc(40);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(40);
    chk({7'h0, e}, {7'h0, ones});
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] r;
    cyc(10);
    resetn_i <= 1'b1;
    rd8(8'h05, r);
    chk(8'h00, r);
    chk(8'h3f, {2'h0, digital_detector_enable_o,
      analog_detector_enable_o});
    for (int i = 0; i < 4; i++) begin
      wr8(rows[i][0], rows[i][1]);
      rd8(rows[i][0], r);
      chk(rows[i][2], r);
    end
    wr8(8'h05, 8'h30);
    // Raw loss while both detectors are off must not be declared
    digital_signal_loss_detector_i <= 3'h1;
    analog_signal_loss_detector_i  <= 3'h1;
    cyc(5);
    chk(8'h00, {6'h0, digital_detector_enable_o[0],
      analog_detector_enable_o[0]});
    chk(8'h00, {7'h0, signal_loss_o[0]});
    e3_mode_i <= 3'h1;
    cyc(5);
    chk(8'h03, {6'h0, digital_detector_enable_o[0],
      analog_detector_enable_o[0]});
    chk(8'h01, {7'h0, signal_loss_o[0]});
    rd8(8'h18, r);
    chk(8'h11, r);
    cyc(1);
    e3_mode_i <= 3'h0;
    digital_signal_loss_detector_i <= 3'h0;
    analog_signal_loss_detector_i  <= 3'h0;
    wr8(8'h05, 8'h00);
    obs(1'b1);
    chk(8'h01, {7'h0, lvl});
    wr8(8'h05, 8'h08);
    obs(1'b1);
    chk(8'h00, {7'h0, lvl});
    digital_signal_loss_detector_i <= 3'h1;
    wr8(8'h05, 8'h04);
    obs(1'b0);
    chk(8'h01, {7'h0, signal_loss_o[0]});
    wr8(8'h05, 8'h00);
    obs(1'b1);
    wr8(8'h05, 8'h04);
    digital_signal_loss_detector_i <= 3'h0;
    obs(1'b1);
    wr8(8'h05, 8'h01);
    wr8(8'h0d, 8'h03);
    wr8(8'h15, 8'h01);
    cyc(3);
    chk(8'h07, {5'h0, equalizer_enable_o});
    chk(8'h02, {5'h0, monitor_mode_o});
    // Mid-run reset must bring every channel back to its defaults
    resetn_i <= 1'b0;
    cyc(10);
    resetn_i <= 1'b1;
    rd8(8'h0d, r);
    chk(8'h00, r);
    chk(8'h3f, {2'h0, digital_detector_enable_o,
      analog_detector_enable_o});
    chk(8'h00, {2'h0, monitor_mode_o, equalizer_enable_o});
    end_of_test();
  end
endmodule
